// ==== core/dei_pkg.sv ====
// Purpose: Shared constants for the converter event status block.
// Assumes: Register port frames are 16 instruction bits then 8 data bits.
// Notes:   Addresses are 15-bit register offsets of the serial port.

package dei_pkg;

  // ------------------------------------------------------------------
  // Serial frame layout
  // ------------------------------------------------------------------
  localparam int          ADDR_W      = 15;
  localparam int          DATA_W      = 8;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  INSTR_BITS  = 5'h10;  // R/W bit plus address
  localparam logic [4:0]  FRAME_BITS  = 5'h18;  // Instruction plus one byte
  localparam int          RW_BIT      = 15;     // 1 = read

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [14:0] ADDR_CH_ERR = 15'h0024;
  localparam logic [14:0] ADDR_PAIR_A = 15'h0025;
  localparam logic [14:0] ADDR_PAIR_B = 15'h0026;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_CH0_FAIL   = 0;
  localparam int BIT_CH1_FAIL   = 1;
  localparam int BIT_A_TRIP     = 0;
  localparam int BIT_A_WINDOW   = 1;
  localparam int BIT_A_ROTATE   = 2;
  localparam int BIT_A_LOCK     = 3;
  localparam int BIT_A_OSC      = 4;
  localparam int BIT_A_BLANK    = 5;
  localparam int BIT_A_POWER    = 7;
  localparam int BIT_B_POWER    = 7;

  // ------------------------------------------------------------------
  // Implemented bits and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  IMPL_CH_ERR  = 8'h03;
  localparam logic [7:0]  IMPL_PAIR_A  = 8'hbf;  // Bit 6 reserved
  localparam logic [7:0]  IMPL_PAIR_B  = 8'h80;  // Bit 6 and below reserved
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  READ_ZERO    = 8'h00;

endpackage : dei_pkg

// ==== core/dei_spi_port.sv ====
// Purpose: Serial register port slave, oversampled by the core clock.
// Assumes: Serial clock low phase longer than three core clocks, as sdo lags each fall.
// Notes:   Mode 0 framing, MSB first, one data byte per frame.

`timescale 1ns/1ps

module dei_spi_port (
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic                         spi_sclk,
  input  wire logic                         spi_csn,
  input  wire logic                         spi_sdi,
  input  wire logic [dei_pkg::DATA_W-1:0]   rd_data,
  output logic                              spi_sdo,
  output logic                              spi_sdo_oe_n,
  output logic      [dei_pkg::ADDR_W-1:0]   reg_addr,
  output logic                              wr_strobe,
  output logic      [dei_pkg::DATA_W-1:0]   wr_data
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic                         sclk_m, sclk_s, sclk_d;
  logic                         csn_m, csn_s;
  logic                         sdi_m, sdi_s;
  logic [dei_pkg::CNT_W-1:0]    bit_cnt;
  logic [15:0]                  instr;
  logic [dei_pkg::DATA_W-1:0]   wshift;
  logic [dei_pkg::DATA_W-1:0]   rshift;
  logic                         instr_done;

  // Two stages on every pin, third stage only for edge detect
  always_ff @(posedge clock) begin
    if (!resetn) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {csn_m, csn_s}           <= 2'h3;
      {sdi_m, sdi_s}           <= 2'h0;
    end else begin
      {sclk_m, sclk_s, sclk_d} <= {spi_sclk, sclk_m, sclk_s};
      {csn_m, csn_s}           <= {spi_csn, csn_m};
      {sdi_m, sdi_s}           <= {spi_sdi, sdi_m};
    end
  end

  // ------------------------------------------------------------------
  // Edge and frame decode
  // ------------------------------------------------------------------
  wire sclk_rise = sclk_s & ~sclk_d & ~csn_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~csn_s;
  wire in_instr  = bit_cnt < dei_pkg::INSTR_BITS;
  wire in_frame  = bit_cnt < dei_pkg::FRAME_BITS;
  wire last_ibit = sclk_rise & (bit_cnt == dei_pkg::INSTR_BITS - 5'h01);
  wire last_dbit = sclk_rise & (bit_cnt == dei_pkg::FRAME_BITS - 5'h01);
  wire is_read   = instr[dei_pkg::RW_BIT];
  wire rd_shift  = sclk_fall & is_read & ~in_instr & in_frame
                   & (bit_cnt != dei_pkg::INSTR_BITS);

  assign reg_addr = instr[dei_pkg::ADDR_W-1:0];

  // Bit counter and input shifters, extra bits ignored
  always_ff @(posedge clock) begin
    if (!resetn || csn_s) begin
      bit_cnt <= '0;
    end else if (sclk_rise && in_frame) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      instr  <= 16'h0000;
      wshift <= 8'h00;
    end else if (sclk_rise && in_instr) begin
      instr  <= {instr[14:0], sdi_s};
    end else if (sclk_rise && in_frame) begin
      wshift <= {wshift[6:0], sdi_s};
    end
  end

  // Write strobe after the last data bit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_strobe  <= 1'b0;
      wr_data    <= 8'h00;
      instr_done <= 1'b0;
    end else begin
      wr_strobe  <= last_dbit & ~is_read;
      instr_done <= last_ibit;
      if (last_dbit) begin
        wr_data <= {wshift[6:0], sdi_s};
      end
    end
  end

  // Read data loaded after the instruction, shifted on falling edges
  always_ff @(posedge clock) begin
    if (!resetn || csn_s) begin
      rshift       <= 8'h00;
      spi_sdo      <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else if (instr_done && is_read) begin
      rshift       <= rd_data;
      spi_sdo      <= rd_data[7];
      spi_sdo_oe_n <= 1'b0;
    end else if (rd_shift) begin
      rshift       <= {rshift[6:0], 1'b0};
      spi_sdo      <= rshift[6];
    end
  end

endmodule : dei_spi_port

// ==== core/dei_status_core.sv ====
// Purpose: Event status flags with live or latched view and interrupt.
// Assumes: Event and mode inputs come from logic on the same clock.
// Notes:   Registers reached only through the serial register port.

`timescale 1ns/1ps

module dei_status_core (
  input  wire logic  clock,
  input  wire logic  resetn,
  // Serial register port pins
  input  wire logic  spi_sclk,
  input  wire logic  spi_csn,
  input  wire logic  spi_sdi,
  output logic       spi_sdo,
  output logic       spi_sdo_oe_n,
  // Event conditions
  input  wire logic  ch1_pattern_fail,
  input  wire logic  ch0_pattern_fail,
  input  wire logic  pair_a_power_over,
  input  wire logic  pair_a_blank_finished,
  input  wire logic  pair_a_osc_align_trip,
  input  wire logic  pair_a_lmfc_locked,
  input  wire logic  pair_a_lmfc_rotated,
  input  wire logic  pair_a_lmfc_out_of_window,
  input  wire logic  pair_a_lmfc_tripped,
  input  wire logic  pair_b_power_over,
  // Per event latch mode bits
  input  wire logic  ch1_pattern_latch_mode,
  input  wire logic  ch0_pattern_latch_mode,
  input  wire logic  pair_a_power_latch_mode,
  input  wire logic  pair_a_blank_latch_mode,
  input  wire logic  pair_a_osc_latch_mode,
  input  wire logic  pair_a_lock_latch_mode,
  input  wire logic  pair_a_rotate_latch_mode,
  input  wire logic  pair_a_window_latch_mode,
  input  wire logic  pair_a_trip_latch_mode,
  input  wire logic  pair_b_power_latch_mode,
  // Shared interrupt
  output logic       irq_n
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [dei_pkg::ADDR_W-1:0]  reg_addr;
  logic                        wr_strobe;
  logic [dei_pkg::DATA_W-1:0]  wr_data;
  logic [dei_pkg::DATA_W-1:0]  rd_data;
  logic [7:0]                  ev_ch, ev_a, ev_b;
  logic [7:0]                  md_ch, md_a, md_b;
  logic [23:0]                 ev_all;
  logic [23:0]                 md_all;
  logic [23:0]                 clr_all;
  logic [23:0]                 held;
  logic [23:0]                 view;
  logic                        next_irq_n;

  // Implemented bits, channel byte lowest; a constant, so the
  // generate loop below builds no flip-flops for reserved bits
  localparam logic [23:0]      IMPL_ALL = {dei_pkg::IMPL_PAIR_B,
                                           dei_pkg::IMPL_PAIR_A,
                                           dei_pkg::IMPL_CH_ERR};

  // ------------------------------------------------------------------
  // Serial register port
  // ------------------------------------------------------------------
  dei_spi_port u_port (
    .clock        (clock),
    .resetn       (resetn),
    .spi_sclk     (spi_sclk),
    .spi_csn      (spi_csn),
    .spi_sdi      (spi_sdi),
    .rd_data      (rd_data),
    .spi_sdo      (spi_sdo),
    .spi_sdo_oe_n (spi_sdo_oe_n),
    .reg_addr     (reg_addr),
    .wr_strobe    (wr_strobe),
    .wr_data      (wr_data)
  );

  // ------------------------------------------------------------------
  // Event placement into register bits
  // ------------------------------------------------------------------
  // Channel pattern byte
  always_comb begin
    ev_ch = dei_pkg::STATUS_RESET;
    md_ch = dei_pkg::STATUS_RESET;
    ev_ch[dei_pkg::BIT_CH1_FAIL] = ch1_pattern_fail;
    md_ch[dei_pkg::BIT_CH1_FAIL] = ch1_pattern_latch_mode;
    ev_ch[dei_pkg::BIT_CH0_FAIL] = ch0_pattern_fail;
    md_ch[dei_pkg::BIT_CH0_FAIL] = ch0_pattern_latch_mode;
  end

  // Pair A byte, bit 6 stays zero
  always_comb begin
    ev_a = dei_pkg::STATUS_RESET;
    md_a = dei_pkg::STATUS_RESET;
    ev_a[dei_pkg::BIT_A_POWER]  = pair_a_power_over;
    md_a[dei_pkg::BIT_A_POWER]  = pair_a_power_latch_mode;
    ev_a[dei_pkg::BIT_A_BLANK]  = pair_a_blank_finished;
    md_a[dei_pkg::BIT_A_BLANK]  = pair_a_blank_latch_mode;
    ev_a[dei_pkg::BIT_A_OSC]    = pair_a_osc_align_trip;
    md_a[dei_pkg::BIT_A_OSC]    = pair_a_osc_latch_mode;
    ev_a[dei_pkg::BIT_A_LOCK]   = pair_a_lmfc_locked;
    md_a[dei_pkg::BIT_A_LOCK]   = pair_a_lock_latch_mode;
    ev_a[dei_pkg::BIT_A_ROTATE] = pair_a_lmfc_rotated;
    md_a[dei_pkg::BIT_A_ROTATE] = pair_a_rotate_latch_mode;
    ev_a[dei_pkg::BIT_A_WINDOW] = pair_a_lmfc_out_of_window;
    md_a[dei_pkg::BIT_A_WINDOW] = pair_a_window_latch_mode;
    ev_a[dei_pkg::BIT_A_TRIP]   = pair_a_lmfc_tripped;
    md_a[dei_pkg::BIT_A_TRIP]   = pair_a_trip_latch_mode;
  end

  // Pair B byte, only the power bit exists
  always_comb begin
    ev_b = dei_pkg::STATUS_RESET;
    md_b = dei_pkg::STATUS_RESET;
    ev_b[dei_pkg::BIT_B_POWER] = pair_b_power_over;
    md_b[dei_pkg::BIT_B_POWER] = pair_b_power_latch_mode;
  end

  // Flat vectors, channel byte lowest
  assign ev_all   = {ev_b, ev_a, ev_ch};
  assign md_all   = {md_b, md_a, md_ch};

  // ------------------------------------------------------------------
  // Write one to clear decode
  // ------------------------------------------------------------------
  wire hit_ch = reg_addr == dei_pkg::ADDR_CH_ERR;
  wire hit_a  = reg_addr == dei_pkg::ADDR_PAIR_A;
  wire hit_b  = reg_addr == dei_pkg::ADDR_PAIR_B;

  // ones in the written byte clear
  assign clr_all = {(wr_strobe & hit_b)  ? wr_data : dei_pkg::READ_ZERO,
                    (wr_strobe & hit_a)  ? wr_data : dei_pkg::READ_ZERO,
                    (wr_strobe & hit_ch) ? wr_data : dei_pkg::READ_ZERO};

  // ------------------------------------------------------------------
  // Per flag storage
  // ------------------------------------------------------------------
  for (genvar g = 0; g < 24; g++) begin : g_flag
    if (IMPL_ALL[g]) begin : g_impl
      // Flag lives only in latch mode; dropping the mode clears it
      logic ev_prev;
      logic flag;
      // Rising edge of the event condition
      wire  rise      = ev_all[g] & ~ev_prev;
      // set wins over a clear in the same cycle
      wire  next_flag = md_all[g] & ((flag & ~clr_all[g]) | rise);

      // Edge history and held flag
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ev_prev <= 1'b0;
          flag    <= 1'b0;
        end else begin
          ev_prev <= ev_all[g];
          flag    <= next_flag;
        end
      end

      assign held[g] = flag;
      assign view[g] = md_all[g] ? flag : ev_all[g];
    end else begin : g_rsvd
      // Reserved bits read zero
      assign held[g] = 1'b0;
      assign view[g] = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  // Unmapped addresses read zero
  assign rd_data = hit_ch ? view[7:0]   :
                   hit_a  ? view[15:8]  :
                   hit_b  ? view[23:16] : dei_pkg::READ_ZERO;

  // ------------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------------
  // low while any held flag set
  assign next_irq_n = ~(|held);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= next_irq_n;
    end
  end

endmodule : dei_status_core

// ==== dv/dei_status_core_checker.sv ====
// Purpose: Checks interrupt and serial port timing of the status block.
// Assumes: Events and modes change on core clock edges.
// Notes:   Sees only the top module ports.

`timescale 1ns/1ps

module dei_status_core_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n,
  input wire logic ch1_pattern_fail,
  input wire logic ch0_pattern_fail,
  input wire logic pair_a_power_over,
  input wire logic pair_a_blank_finished,
  input wire logic pair_a_osc_align_trip,
  input wire logic pair_a_lmfc_locked,
  input wire logic pair_a_lmfc_rotated,
  input wire logic pair_a_lmfc_out_of_window,
  input wire logic pair_a_lmfc_tripped,
  input wire logic pair_b_power_over,
  input wire logic ch1_pattern_latch_mode,
  input wire logic ch0_pattern_latch_mode,
  input wire logic pair_a_power_latch_mode,
  input wire logic pair_a_blank_latch_mode,
  input wire logic pair_a_osc_latch_mode,
  input wire logic pair_a_lock_latch_mode,
  input wire logic pair_a_rotate_latch_mode,
  input wire logic pair_a_window_latch_mode,
  input wire logic pair_a_trip_latch_mode,
  input wire logic irq_n,
  input wire logic pair_b_power_latch_mode
);
  // ----------------------------------------------------------------
  // Event vectors and helpers
  // ----------------------------------------------------------------
  logic [9:0] ev;
  logic [9:0] md;
  logic [9:0] ev_d;
  logic [9:0] md_d;
  logic [9:0] rise_q;
  logic [3:0] quiet;

  // Events packed ch0 first, pair B power last
  assign ev = {pair_b_power_over, pair_a_power_over, pair_a_blank_finished,
    pair_a_osc_align_trip, pair_a_lmfc_locked, pair_a_lmfc_rotated,
    pair_a_lmfc_out_of_window, pair_a_lmfc_tripped, ch1_pattern_fail,
    ch0_pattern_fail};
  assign md = {pair_b_power_latch_mode, pair_a_power_latch_mode,
    pair_a_blank_latch_mode, pair_a_osc_latch_mode, pair_a_lock_latch_mode,
    pair_a_rotate_latch_mode, pair_a_window_latch_mode,
    pair_a_trip_latch_mode, ch1_pattern_latch_mode, ch0_pattern_latch_mode};

  // Edge history and quiet time with no frame or mode change
  always_ff @(posedge clock) begin
    ev_d   <= ev;
    md_d   <= md;
    rise_q <= ev & ~ev_d & md;
    if (!resetn || !spi_csn || md != md_d) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_new_edge;
    spi_csn && (ev & ~$past(ev) & md) != 10'h000;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // released after reset
  a_reset_irq_idle: assert property (disable iff (1'b0)
    !resetn |=> irq_n) else $error("irq_n low after reset");
  a_latch_sets_irq: assert property (
    s_new_edge |-> ##[1:3] !irq_n) else $error("latched edge gave no irq");
  a_live_no_irq: assert property (
    (md == 10'h000) [*4] |-> irq_n) else $error("irq with no latch mode");
  a_irq_holds_low: assert property (
    (quiet >= 4'h6 && !irq_n) |=> !irq_n) else $error("irq released alone");
  a_irq_rise_cause: assert property (
    $rose(irq_n) |-> quiet < 4'ha) else $error("irq released without cause");
  a_oe_only_frame: assert property (
    !spi_sdo_oe_n |-> quiet < 4'h6) else $error("sdo driven outside frame");
  a_fall_needs_mode: assert property (
    $fell(irq_n) |-> ($past(md) | $past(md, 2)) != 10'h000)
    else $error("irq fell with modes low");
  a_fall_needs_edge: assert property (
    $fell(irq_n) |-> ($past(rise_q) | $past(rise_q, 2) | $past(rise_q, 3))
    != 10'h000) else $error("irq fell without event edge");

endmodule : dei_status_core_checker

// ==== dv/dei_status_core_test.sv ====
// Purpose: Self-checking bench for the event status block.
// Assumes: Serial clock runs near one thirteenth of the core clock.
// Notes:   Event bits run ch0, ch1, pair A bits 0..5 and 7, pair B.

`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module dei_status_core_test;
  logic       clock, resetn, spi_sclk, spi_csn, spi_sdi;
  logic       spi_sdo, spi_sdo_oe_n, irq_n;
  logic [9:0] ev, md;
  logic [7:0] q;
  int         n_mismatch, n_checks, cyc;
  int         bp[10] = '{0, 1, 0, 1, 2, 3, 4, 5, 7, 7};

  dei_status_core dei_status_core_inst (
    .clock, .resetn, .spi_sclk, .spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
    .irq_n, .ch0_pattern_fail(ev[0]), .ch1_pattern_fail(ev[1]),
    .pair_a_lmfc_tripped(ev[2]), .pair_a_lmfc_out_of_window(ev[3]),
    .pair_a_lmfc_rotated(ev[4]), .pair_a_lmfc_locked(ev[5]),
    .pair_a_osc_align_trip(ev[6]), .pair_a_blank_finished(ev[7]),
    .pair_a_power_over(ev[8]), .pair_b_power_over(ev[9]),
    .ch0_pattern_latch_mode(md[0]), .ch1_pattern_latch_mode(md[1]),
    .pair_a_trip_latch_mode(md[2]), .pair_a_window_latch_mode(md[3]),
    .pair_a_rotate_latch_mode(md[4]), .pair_a_lock_latch_mode(md[5]),
    .pair_a_osc_latch_mode(md[6]), .pair_a_blank_latch_mode(md[7]),
    .pair_a_power_latch_mode(md[8]), .pair_b_power_latch_mode(md[9]));

  // Clock and cycle ceiling
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [14:0] adr(input int i);
    adr = i < 2 ? dei_pkg::ADDR_CH_ERR
        : i == 9 ? dei_pkg::ADDR_PAIR_B : dei_pkg::ADDR_PAIR_A;
  endfunction : adr

  // One frame, slow serial clock, sdo sampled late in low phase, half a clock before the rise
  task automatic xfer(input logic r, input logic [14:0] a,
                      input logic [7:0] d);
    logic [23:0] f;
    f = {r, a, d};
    q = 8'h00;
    @(posedge clock) spi_csn <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (6) @(posedge clock);
      @(negedge clock) if (i < 8) q[i] = spi_sdo;
      if (r && i < 8) `CHK("oe_n", 1'b0, spi_sdo_oe_n)
      @(posedge clock) spi_sclk <= 1'b1;
      repeat (6) @(posedge clock);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    spi_csn <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : xfer

  task automatic rd(input logic [14:0] a, input logic [7:0] e,
                    input string nm);
    xfer(1'b1, a, 8'h00);
    `CHK(nm, e, q)
  endtask : rd

  task automatic pulse(input logic [9:0] m);
    @(posedge clock) ev <= m;
    @(posedge clock) ev <= 10'h000;
    repeat (4) @(posedge clock);
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("oe_n", 1'b1, spi_sdo_oe_n)
    rd(dei_pkg::ADDR_CH_ERR, 8'h00, "ch reset");
    rd(dei_pkg::ADDR_PAIR_A, 8'h00, "a reset");
    rd(dei_pkg::ADDR_PAIR_B, 8'h00, "b reset");
    rd(15'h0027, 8'h00, "unmapped");
  endtask : t_reset

  task t_live;
    for (int i = 0; i < 10; i++) begin
      @(posedge clock) ev <= 10'h001 << i;
      rd(adr(i), 8'h01 << bp[i], "live bit");
      `CHK("live irq_n", 1'b1, irq_n)
    end
    @(posedge clock) ev <= 10'h3ff;
    rd(dei_pkg::ADDR_CH_ERR, 8'h03, "ch all");
    rd(dei_pkg::ADDR_PAIR_A, 8'hbf, "a all");
    rd(dei_pkg::ADDR_PAIR_B, 8'h80, "b all");
    @(posedge clock) ev <= 10'h000;
    rd(dei_pkg::ADDR_PAIR_A, 8'h00, "live drop");
  endtask : t_live

  task t_latch;
    @(posedge clock) md <= 10'h3ff;
    pulse(10'h3ff);
    `CHK("latch irq_n", 1'b0, irq_n)
    xfer(1'b0, dei_pkg::ADDR_PAIR_A, 8'h00);
    xfer(1'b0, 15'h0027, 8'hff);
    rd(dei_pkg::ADDR_PAIR_A, 8'hbf, "held a");
    xfer(1'b0, dei_pkg::ADDR_PAIR_A, 8'h08);
    rd(dei_pkg::ADDR_PAIR_A, 8'hb7, "clear one");
    xfer(1'b0, dei_pkg::ADDR_PAIR_A, 8'hff);
    xfer(1'b0, dei_pkg::ADDR_CH_ERR, 8'hff);
    rd(dei_pkg::ADDR_CH_ERR, 8'h00, "clear ch");
    `CHK("still irq_n", 1'b0, irq_n)
    xfer(1'b0, dei_pkg::ADDR_PAIR_B, 8'h80);
    rd(dei_pkg::ADDR_PAIR_B, 8'h00, "clear b");
    `CHK("free irq_n", 1'b1, irq_n)
  endtask : t_latch

  task t_drop;
    pulse(10'h002);
    `CHK("ch1 irq_n", 1'b0, irq_n)
    @(posedge clock) md <= 10'h000;
    repeat (5) @(posedge clock);
    `CHK("drop irq_n", 1'b1, irq_n)
    rd(dei_pkg::ADDR_CH_ERR, 8'h00, "drop ch");
  endtask : t_drop

  task give_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    resetn = 1'b0;
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
    ev = 10'h000;
    md = 10'h000;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset;
    t_live;
    t_latch;
    t_drop;
    give_verdict;
  end
endmodule : dei_status_core_test

bind dei_status_core dei_status_core_checker dei_status_core_checker_inst (
  .clock, .resetn, .spi_sclk, .spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
  .ch1_pattern_fail, .ch0_pattern_fail, .pair_a_power_over,
  .pair_a_blank_finished, .pair_a_osc_align_trip, .pair_a_lmfc_locked,
  .pair_a_lmfc_rotated, .pair_a_lmfc_out_of_window, .pair_a_lmfc_tripped,
  .pair_b_power_over, .ch1_pattern_latch_mode, .ch0_pattern_latch_mode,
  .pair_a_power_latch_mode, .pair_a_blank_latch_mode, .pair_a_osc_latch_mode,
  .pair_a_lock_latch_mode, .pair_a_rotate_latch_mode, .irq_n,
  .pair_a_window_latch_mode, .pair_a_trip_latch_mode,
  .pair_b_power_latch_mode);
